// ### src/slseq_pkg.sv
/*
 * Shared constants for the source list sequencer: register map, control
 * field positions, reset values, trigger source codes, states and the
 * built-in demonstration list.
 * Assumes a 25 MHz system clock; all times are held in clock cycles.
 */
package slseq_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CYCLES = 8'h04;
    localparam logic [7:0] REG_POINTS = 8'h08;
    localparam logic [7:0] REG_SAMPLES = 8'h0c;
    localparam logic [7:0] REG_SAMP_TIME = 8'h10;
    localparam logic [7:0] REG_SRC_DELAY = 8'h14;
    localparam logic [7:0] REG_LIMIT = 8'h18;
    localparam logic [7:0] REG_MEM_ADDR = 8'h1c;
    localparam logic [7:0] REG_MEM_VOLT = 8'h20;
    localparam logic [7:0] REG_MEM_ILIM = 8'h24;
    localparam logic [7:0] REG_MEM_DWELL = 8'h28;
    localparam logic [7:0] REG_COMMAND = 8'h2c;
    localparam logic [7:0] REG_STATUS = 8'h30;
    localparam logic [7:0] REG_TRIG_CFG = 8'h34;

    // Control register fields
    localparam int CTRL_OUT_EN = 0;
    localparam int CTRL_POINT_HOLD = 1;
    localparam int CTRL_END_ZERO = 2;
    localparam int CTRL_SWEEP = 3;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_AUTOZERO = 6;
    localparam int CTRL_ABORT_LIM = 7;
    localparam int CTRL_SLOT_LSB = 8;
    localparam int CTRL_INIT_CONT = 12;

    // Command register bits, write one to act
    localparam int CMD_ENABLE = 0;
    localparam int CMD_INIT = 1;
    localparam int CMD_BUS_TRIG = 2;
    localparam int CMD_MAN_TRIG = 3;
    localparam int CMD_ABORT = 4;

    localparam logic [1:0] TSRC_IMM = 2'h0;
    localparam logic [1:0] TSRC_EXT = 2'h1;
    localparam logic [1:0] TSRC_BUS = 2'h2;
    localparam logic [1:0] TSRC_MAN = 2'h3;

    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CYCLES_RESET = 16'h0001;
    localparam logic [6:0] POINTS_RESET = 7'h04;
    localparam logic [15:0] SAMPLES_RESET = 16'h000a;
    localparam logic [15:0] SAMP_TIME_RESET = 16'h0064;
    localparam logic [15:0] SRC_DELAY_RESET = 16'h0032;
    localparam logic [15:0] LIMIT_RESET = 16'hffff;

    // End-at-zero levels: mV and mA
    localparam logic [15:0] END_ZERO_VOLT = 16'h0000;
    localparam logic [15:0] END_ZERO_ILIM = 16'h0064;

    localparam logic [3:0] DEMO_SLOT = 4'h0;
    localparam logic [3:0] MAX_SLOT = 4'h9;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAIT_TRIG = 5'h02,
        ST_LOAD = 5'h04,
        ST_SETTLE = 5'h08,
        ST_MEASURE = 5'h10
    } slseq_state_t;

    // Demo step: {volt mV, current limit mA, dwell cycles}
    function automatic logic [47:0] demo_step(input logic [1:0] pt);
        logic [47:0] v;
        v = 48'h0;
        case (pt)
            2'h0: v = {16'h03e8, 16'h01f4, 16'h0190};
            2'h1: v = {16'h07d0, 16'h01f4, 16'h0190};
            2'h2: v = {16'h0bb8, 16'h01f4, 16'h0190};
            default: v = {16'h0fa0, 16'h01f4, 16'h0190};
        endcase
        return v;
    endfunction : demo_step

endpackage : slseq_pkg

// ### src/slseq_sync.sv
/*
 * Two flip-flop synchroniser for pin inputs.
 * Assumes inputs are asynchronous levels or pulses wider than two clocks.
 */
module slseq_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : slseq_sync

// ### src/slseq_top.sv
/*
 * Source list sequencer: AXI4-Lite register file, list step store and
 * the sequencing state machine that drives source levels, sample strobes
 * and the measure-complete line.
 * Assumes one 25 MHz clock, an asynchronous trigger-in pin, and a
 * measurement path on the same clock that answers each sample strobe.
 */
// Functional notes
// - List slot 1 to 9 selectable; slot 0 runs the built-in demo list.
// - Time hold: each step lasts its dwell time, then advances.
// - Point hold: each step lasts until preset sample count reached.
// - End-at-zero on: finish at 0 V and 0.1 A limit.
// - End-at-zero off: keep last step levels after finishing.
// - Step mode: one step per trigger, measure-complete after each step.
// - Sweep mode: whole list per trigger, measure-complete after each cycle.
// - Whole list repeats the programmed number of cycles.
// - Turning output off aborts a running list at once.
// - Local start forces immediate source, point/cycle counts, no continuous.
// - After last cycle go idle; manual trigger restarts same list.
// - Time hold window is dwell minus delay; samples fill that window.
// - Point hold window is samples times sample time; dwell ignored.
// - Measure-complete drives digital I/O line 2.
// - Immediate source in step mode: next step follows without waiting.
// - Other sources in step mode: wait for trigger after measure-complete.
// - Triggers during delay, measure or dwell are discarded.
// - Abort on limit exceeded or trigger model abort request.
// - User stop cancels all pending list work; no further steps sourced. A stop in the load cycle still applies that step's levels.
// - Autozero on doubles each sample time for fresh reference readings.
module slseq_top #(
    parameter int PTS_W = 6
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trig_in_pin,
    input wire logic [15:0] meas_value,
    input wire logic meas_valid,
    output logic [15:0] src_volt,
    output logic [15:0] src_ilim,
    output logic output_on,
    output logic sample_strobe,
    output logic autozero_en,
    output logic dio_line2,
    output logic list_running
);
    localparam int MEM_DEPTH = 1 << (4 + PTS_W);

    typedef struct packed {
        slseq_pkg::slseq_state_t state;
        logic [15:0] ctrl, cycles;
        logic [6:0] points;
        logic [15:0] samples, samp_time, src_delay, limit;
        logic [9:0] mem_addr;
        logic [15:0] mem_volt, mem_ilim, mem_dwell;
        logic mem_we;
        logic [1:0] eff_src;
        logic [6:0] trig_count;
        logic [15:0] arm_count;
        logic init_cont;
        logic [3:0] slot;
        logic [PTS_W-1:0] point;
        logic [15:0] cycle, dwell, tmr;
        logic [16:0] stmr;
        logic [15:0] scnt, volt, ilim;
        logic done_pulse, samp_pulse, aborted, has_run, trig_last, aw_have, w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } slseq_regs_t;

    slseq_regs_t s_q, s_d;
    logic [47:0] step_mem [0:MEM_DEPTH-1];
    logic trig_sync;
    logic [32:0] rd_hit, old_hit;
    logic [31:0] wr_val;
    logic [4:0] cmd;
    logic [3:0] slot_sel;
    logic [47:0] step_val;
    logic trig_ev, abort_req, start_local, start_any, last_pt, last_cy, step_done;
    logic [16:0] period;

    slseq_sync #(
        .W(1)
    ) u_trig_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(trig_in_pin),
        .sync_out(trig_sync)
    );

    // Register read decode: {hit, data}; also used for byte-lane merge on write
    function automatic logic [32:0] reg_rd(input logic [7:0] a, input slseq_regs_t r);
        logic [32:0] v;
        v = {1'b1, 32'h0};
        case ({a[7:2], 2'b00})
            slseq_pkg::REG_CTRL: v[15:0] = r.ctrl;
            slseq_pkg::REG_CYCLES: v[15:0] = r.cycles;
            slseq_pkg::REG_POINTS: v[6:0] = r.points;
            slseq_pkg::REG_SAMPLES: v[15:0] = r.samples;
            slseq_pkg::REG_SAMP_TIME: v[15:0] = r.samp_time;
            slseq_pkg::REG_SRC_DELAY: v[15:0] = r.src_delay;
            slseq_pkg::REG_LIMIT: v[15:0] = r.limit;
            slseq_pkg::REG_MEM_ADDR: v[9:0] = r.mem_addr;
            slseq_pkg::REG_MEM_VOLT: v[15:0] = r.mem_volt;
            slseq_pkg::REG_MEM_ILIM: v[15:0] = r.mem_ilim;
            slseq_pkg::REG_MEM_DWELL: v[15:0] = r.mem_dwell;
            slseq_pkg::REG_COMMAND: v[31:0] = 32'h0;
            slseq_pkg::REG_STATUS: v[31:0] = {r.aborted, (r.state != slseq_pkg::ST_IDLE),
                1'b0, r.state, 2'b00, 6'(r.point), r.cycle};
            slseq_pkg::REG_TRIG_CFG: v[31:0] = {5'h0, r.init_cont, r.eff_src,
                1'b0, r.trig_count, r.arm_count};
            default: v = {1'b0, 32'h0};
        endcase
        return v;
    endfunction : reg_rd

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return v;
    endfunction : wmerge

    // Bad slot numbers fall back to the demo list
    assign slot_sel = (s_q.slot > slseq_pkg::MAX_SLOT) ? slseq_pkg::DEMO_SLOT : s_q.slot;
    assign step_val = (slot_sel == slseq_pkg::DEMO_SLOT) ? slseq_pkg::demo_step(s_q.point[1:0])
        : step_mem[{slot_sel, s_q.point}];
    assign rd_hit = reg_rd(s_axi_araddr, s_q);
    assign old_hit = reg_rd(s_q.awaddr, s_q);
    assign wr_val = wmerge(old_hit[31:0], s_q.wdata, s_q.wstrb);
    // Autozero takes a reference and a zero reading per sample
    assign period = s_q.ctrl[slseq_pkg::CTRL_AUTOZERO] ? {s_q.samp_time, 1'b0}
        : {1'b0, s_q.samp_time};
    assign last_pt = ({1'b0, s_q.point} == 7'(s_q.trig_count - 7'd1));
    assign last_cy = (s_q.cycle == 16'(s_q.arm_count - 16'd1));

    always_comb begin
        s_d = s_q;
        cmd = 5'h0;
        s_d.mem_we = 1'b0;
        s_d.done_pulse = 1'b0;
        s_d.samp_pulse = 1'b0;
        step_done = 1'b0;
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_awvalid && !s_q.aw_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_have && !s_q.bvalid) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = old_hit[32] ? slseq_pkg::RESP_OKAY : slseq_pkg::RESP_SLVERR;
            case ({s_q.awaddr[7:2], 2'b00})
                slseq_pkg::REG_CTRL: s_d.ctrl = wr_val[15:0];
                slseq_pkg::REG_CYCLES: s_d.cycles = wr_val[15:0];
                slseq_pkg::REG_POINTS: s_d.points = wr_val[6:0];
                slseq_pkg::REG_SAMPLES: s_d.samples = wr_val[15:0];
                slseq_pkg::REG_SAMP_TIME: s_d.samp_time = wr_val[15:0];
                slseq_pkg::REG_SRC_DELAY: s_d.src_delay = wr_val[15:0];
                slseq_pkg::REG_LIMIT: s_d.limit = wr_val[15:0];
                slseq_pkg::REG_MEM_ADDR: s_d.mem_addr = wr_val[9:0];
                slseq_pkg::REG_MEM_VOLT: s_d.mem_volt = wr_val[15:0];
                slseq_pkg::REG_MEM_ILIM: s_d.mem_ilim = wr_val[15:0];
                slseq_pkg::REG_MEM_DWELL: begin
                    s_d.mem_dwell = wr_val[15:0];
                    s_d.mem_we = (s_q.mem_addr[9:6] != slseq_pkg::DEMO_SLOT)
                        && (s_q.mem_addr[9:6] <= slseq_pkg::MAX_SLOT);
                end
                slseq_pkg::REG_COMMAND: cmd = wr_val[4:0];
                default: s_d.bresp = old_hit[32] ? slseq_pkg::RESP_OKAY : slseq_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_hit[31:0];
            s_d.rresp = rd_hit[32] ? slseq_pkg::RESP_OKAY : slseq_pkg::RESP_SLVERR;
        end

        // Trigger events only count when waiting; elsewhere they are dropped
        s_d.trig_last = trig_sync;
        trig_ev = ((s_q.eff_src == slseq_pkg::TSRC_EXT) && trig_sync && !s_q.trig_last)
            || ((s_q.eff_src == slseq_pkg::TSRC_BUS) && cmd[slseq_pkg::CMD_BUS_TRIG])
            || ((s_q.eff_src == slseq_pkg::TSRC_MAN) && cmd[slseq_pkg::CMD_MAN_TRIG]);
        abort_req = cmd[slseq_pkg::CMD_ABORT] || cmd[slseq_pkg::CMD_ENABLE];
        if (s_q.ctrl[slseq_pkg::CTRL_OUT_EN] && !s_d.ctrl[slseq_pkg::CTRL_OUT_EN]) begin
            abort_req = 1'b1;
        end
        if (s_q.state == slseq_pkg::ST_MEASURE && s_q.ctrl[slseq_pkg::CTRL_ABORT_LIM]
            && meas_valid && meas_value > s_q.limit) begin
            abort_req = 1'b1;
        end
        start_local = cmd[slseq_pkg::CMD_ENABLE]
            || (cmd[slseq_pkg::CMD_MAN_TRIG] && s_q.has_run);
        start_any = start_local || cmd[slseq_pkg::CMD_INIT];

        unique case (s_q.state)
            slseq_pkg::ST_IDLE: begin
                if (start_any) begin
                    s_d.point = '0;
                    s_d.cycle = 16'h0;
                    s_d.aborted = 1'b0;
                    s_d.has_run = 1'b1;
                    s_d.slot = s_q.ctrl[slseq_pkg::CTRL_SLOT_LSB +: 4];
                    s_d.trig_count = (s_q.points == 7'h0) ? 7'h1 : s_q.points;
                    s_d.arm_count = (s_q.cycles == 16'h0) ? 16'h1 : s_q.cycles;
                    if (start_local) begin
                        s_d.eff_src = slseq_pkg::TSRC_IMM;
                        s_d.init_cont = 1'b0;
                    end else begin
                        s_d.eff_src = s_q.ctrl[slseq_pkg::CTRL_SRC_LSB +: 2];
                        s_d.init_cont = s_q.ctrl[slseq_pkg::CTRL_INIT_CONT];
                    end
                    s_d.state = (start_local
                        || s_q.ctrl[slseq_pkg::CTRL_SRC_LSB +: 2] == slseq_pkg::TSRC_IMM)
                        ? slseq_pkg::ST_LOAD : slseq_pkg::ST_WAIT_TRIG;
                end
            end
            slseq_pkg::ST_WAIT_TRIG: begin
                if (trig_ev) begin
                    s_d.state = slseq_pkg::ST_LOAD;
                end
            end
            slseq_pkg::ST_LOAD: begin
                s_d.volt = step_val[47:32];
                s_d.ilim = step_val[31:16];
                s_d.dwell = step_val[15:0];
                s_d.tmr = s_q.src_delay;
                s_d.state = slseq_pkg::ST_SETTLE;
            end
            slseq_pkg::ST_SETTLE: begin
                if (s_q.tmr == 16'h0) begin
                    s_d.state = slseq_pkg::ST_MEASURE;
                    s_d.stmr = 17'h0;
                    s_d.scnt = 16'h0;
                    // Window is what remains of the dwell after the source delay
                    s_d.tmr = (s_q.dwell > s_q.src_delay)
                        ? 16'(s_q.dwell - s_q.src_delay) : 16'h0;
                end else begin
                    s_d.tmr = 16'(s_q.tmr - 16'd1);
                end
            end
            slseq_pkg::ST_MEASURE: begin
                if (s_q.ctrl[slseq_pkg::CTRL_POINT_HOLD]) begin
                    step_done = (s_q.scnt >= s_q.samples);
                end else begin
                    step_done = (s_q.tmr == 16'h0);
                    s_d.tmr = step_done ? 16'h0 : 16'(s_q.tmr - 16'd1);
                end
                if (!step_done) begin
                    if (17'(s_q.stmr + 17'd1) >= period) begin
                        s_d.stmr = 17'h0;
                        s_d.samp_pulse = 1'b1;
                        s_d.scnt = 16'(s_q.scnt + 16'd1);
                    end else begin
                        s_d.stmr = 17'(s_q.stmr + 17'd1);
                    end
                end else begin
                    s_d.done_pulse = !s_q.ctrl[slseq_pkg::CTRL_SWEEP] || last_pt;
                    if (last_pt && last_cy && !s_q.init_cont) begin
                        s_d.state = slseq_pkg::ST_IDLE;
                        if (s_q.ctrl[slseq_pkg::CTRL_END_ZERO]) begin
                            s_d.volt = slseq_pkg::END_ZERO_VOLT;
                            s_d.ilim = slseq_pkg::END_ZERO_ILIM;
                        end
                    end else begin
                        s_d.point = last_pt ? '0 : PTS_W'(s_q.point + 1'b1);
                        s_d.cycle = (last_pt && last_cy) ? 16'h0
                            : 16'(s_q.cycle + {15'h0, last_pt});
                        // Immediate source never waits; others wait per step or per cycle
                        s_d.state = (s_q.eff_src == slseq_pkg::TSRC_IMM
                            || (s_q.ctrl[slseq_pkg::CTRL_SWEEP] && !last_pt))
                            ? slseq_pkg::ST_LOAD : slseq_pkg::ST_WAIT_TRIG;
                    end
                end
            end
        endcase

        // Stop wins over the next state and both pulses; levels and counters set that cycle still apply
        if (abort_req && s_q.state != slseq_pkg::ST_IDLE) begin
            s_d.state = slseq_pkg::ST_IDLE;
            s_d.aborted = 1'b1;
            s_d.done_pulse = 1'b0;
            s_d.samp_pulse = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.state <= slseq_pkg::ST_IDLE;
            s_q.ctrl <= slseq_pkg::CTRL_RESET;
            s_q.cycles <= slseq_pkg::CYCLES_RESET;
            s_q.points <= slseq_pkg::POINTS_RESET;
            s_q.samples <= slseq_pkg::SAMPLES_RESET;
            s_q.samp_time <= slseq_pkg::SAMP_TIME_RESET;
            s_q.src_delay <= slseq_pkg::SRC_DELAY_RESET;
            s_q.limit <= slseq_pkg::LIMIT_RESET;
            s_q.trig_count <= slseq_pkg::POINTS_RESET;
            s_q.arm_count <= slseq_pkg::CYCLES_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Step store has no reset; unwritten slots read as unknown levels
    always_ff @(posedge sys_clk) begin
        if (s_q.mem_we) begin
            step_mem[s_q.mem_addr] <= {s_q.mem_volt, s_q.mem_ilim, s_q.mem_dwell};
        end
    end

    assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign src_volt = s_q.volt;
    assign src_ilim = s_q.ilim;
    assign output_on = s_q.ctrl[slseq_pkg::CTRL_OUT_EN];
    assign sample_strobe = s_q.samp_pulse;
    assign autozero_en = s_q.ctrl[slseq_pkg::CTRL_AUTOZERO];
    assign dio_line2 = s_q.done_pulse;
    assign list_running = (s_q.state != slseq_pkg::ST_IDLE);

endmodule : slseq_top

// ### verif/slseq_meas.sv
/* Measurement stand-in: answers each sample strobe with one reading next cycle.
   Assumes the sequencer clock; the reading sits above a lowered abort limit. */
module slseq_meas (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sample_strobe,
    output logic meas_valid,
    output logic [15:0] meas_value
);
    timeunit 1ns / 1ns;
    initial {meas_valid, meas_value} = 17'h0;
    always @(posedge sys_clk or posedge rst) begin
        meas_valid <= !rst && sample_strobe;
        // Between readings the value flips so a stale one never looks fresh
        meas_value <= sample_strobe ? 16'h0200 : ~meas_value;
    end
endmodule : slseq_meas

// ### verif/slseq_sva.sv
/* Checker on the sequencer top ports: bus holds, pulse shapes, stop timing.
   Bound into slseq_top and sees its ports only. */
module slseq_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic dio_line2,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_arready,
    input wire logic output_on,
    input wire logic [15:0] src_volt,
    input wire logic sample_strobe,
    input wire logic list_running
);
    timeunit 1ns / 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_dio; dio_line2 |=> !dio_line2 [*3]; endproperty
    a_dio: assert property (p_dio) else $error("dio pulse too long");
    property p_dio_run; dio_line2 |-> $past(list_running); endproperty
    a_dio_run: assert property (p_dio_run) else $error("dio outside run");
    property p_strb; sample_strobe |-> $past(list_running); endproperty
    a_strb: assert property (p_strb) else $error("strobe outside run");
    property p_lvl; $changed(src_volt) |-> $past(list_running); endproperty
    a_lvl: assert property (p_lvl) else $error("level moved while idle");
    property p_off; $fell(output_on) |-> ##[0:3] !list_running; endproperty
    a_off: assert property (p_off) else $error("run kept after output off");
    property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b: assert property (p_b) else $error("bvalid dropped");
    property p_r; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_r: assert property (p_r) else $error("rvalid dropped");
    property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar: assert property (p_ar) else $error("arready during rvalid");
endmodule : slseq_sva
bind slseq_top slseq_sva sva_u (.*);

// ### verif/testbench.sv
/* Bench top: runs lists through AXI4-Lite register calls and checks outcomes.
   Assumes the measurement stand-in answers every sample strobe. */
module testbench;
    timeunit 1ns / 1ns;
    logic sys_clk = 1'b0, rst = 1'b1, trig_in_pin = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, meas_valid;
    logic output_on, sample_strobe, autozero_en, dio_line2, list_running;
    logic [15:0] meas_value, src_volt, src_ilim;
    int error_cnt = 0, samples_checked = 0, n, m;
    slseq_top dut_u (.*);
    slseq_meas meas_u (.*);
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp) error_cnt++;
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge sys_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata & m}, {a > 8'h34 ? 2'h2 : 2'h0, exp});
    endtask : rd
    // Counts measure-complete pulses and sample strobes until the list drops back to idle
    task automatic run;
        n = 0;
        m = 0;
        repeat (3) @(posedge sys_clk);
        do begin
            @(posedge sys_clk);
            n += int'(dio_line2);
            m += int'(sample_strobe);
        end while (list_running === 1'b1);
    endtask : run
    task automatic end_sim(input int extra);
        error_cnt += extra;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial forever #20 sys_clk = ~sys_clk;
    initial #2000000 end_sim(1);
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h38, 32'hffffffff, 32'h0);
        wr(8'h08, 32'h2);
        wr(8'h2c, 32'h1);
        rd(8'h34, 32'h07ffffff, 32'h00020001);
        run();
        chk(n, 2);
        chk(m, 6);
        chk(src_volt, 16'h07d0);
        wr(8'h2c, 32'h8);
        run();
        chk(n, 2);
        chk(m, 6);
        $display("step test done");
        wr(8'h04, 32'h2);
        // Autozero doubles the sample period: one strobe fits each 350-cycle window
        wr(8'h00, 32'h4c);
        wr(8'h2c, 32'h1);
        run();
        chk(n, 2);
        chk(m, 4);
        chk(autozero_en, 1);
        chk({src_volt, src_ilim}, 32'h64);
        $display("sweep test done");
        wr(8'h18, 32'h100);
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, i < 2 ? 32'h1 : 32'h82);
            wr(8'h2c, 32'h1);
            repeat (300) @(posedge sys_clk);
            wr(i ? 8'h2c : 8'h00, i == 1 ? 32'h10 : 32'h0);
            repeat (3) @(posedge sys_clk);
            chk(list_running, 0);
            rd(8'h30, 32'h80000000, 32'h80000000);
        end
        $display("abort test done");
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h12);
        wr(8'h2c, 32'h2);
        trig_in_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        trig_in_pin <= 1'b0;
        do @(posedge sys_clk); while (dio_line2 !== 1'b1);
        repeat (600) @(posedge sys_clk);
        chk(list_running, 1);
        trig_in_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        trig_in_pin <= 1'b0;
        run();
        chk(n, 1);
        chk(m, 10);
        $display("trigger test done");
        end_sim(0);
    end
endmodule : testbench
